// ===== rtl/bsm_core.sv
// Execution core for logic, multiply, jump, call, skip and branch instructions
// Operation
// - Set-bits ORs immediate into register, updates Z N V S, one cycle.
// - Clear-bits ANDs register with ones-byte minus immediate, Z N V S, one cycle.
// - Test ANDs register with itself, value unchanged, Z N V S, one cycle.
// - Integer multiplies write 16-bit product to r1:r0, update Z C, two cycles.
// - Fractional multiplies shift product left once into r1:r0, Z C, two cycles.
// - Indirect jump loads PC from Z pointer, no flags, two cycles.
// - Indirect call pushes return, loads PC from Z, two or three cycles.
// - Compare-skip skips next when registers equal, PC plus 2 or 3.
// - Skip when selected register bit is zero, same skip timing.
// - Skip when selected register bit is one, no flag change.
// - I/O bit skips test one I/O register bit, clear or set variant.
// - Generic flag branches test chosen flag, target PC+k+1, 1 or 2 cycles.
// - Same-or-higher taken on carry zero, lower taken on carry one.
// - Signed ge taken when N xor V zero, lt when it is one.
// - Half-carry branches taken on H one or zero respectively.
// - Overflow branches taken on V one or zero respectively.
// - Interrupt-state branches taken on I one or zero respectively.
// - Transfer branches taken on T one or zero respectively.
// - Sign flag always equals N xor V.
// - Transfer flag tested is the bit-load and bit-store status bit.
`timescale 1ns/1ps
module bsm_core
  import bsm_pkg::*;
#(
  parameter int PC_WIDTH    = 16,
  parameter int STACK_DEPTH = 16
) (
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  input  wire logic                 ce,
  output logic      [PC_WIDTH-1:0]  imem_addr,
  input  wire logic [15:0]          imem_data,
  output logic      [IO_ADDR_W-1:0] io_addr,
  input  wire logic [7:0]           io_rdata,
  input  wire logic [5:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [7:0]           reg_rdata,
  output bsm_flags_type             flags,
  output logic                      busy
);

  localparam int  SPW  = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;
  localparam bit  WIDE = (PC_WIDTH > NARROW_PC_MAX);
  localparam logic [2:0] X_MUL   = 3'(CYC_MUL - 1);
  localparam logic [2:0] X_INDIRECT_JUMP_OP  = 3'(CYC_INDIRECT_JUMP_OP - 1);
  localparam logic [2:0] X_RELATIVE_JUMP_OP  = 3'(CYC_RELATIVE_JUMP_OP - 1);
  localparam logic [2:0] X_JMP   = 3'(CYC_JMP - 2);
  localparam logic [2:0] X_RELATIVE_SUBROUTINE_OP = 3'((WIDE ? CYC_RELATIVE_SUBROUTINE_OP_W : CYC_RELATIVE_SUBROUTINE_OP_N) - 1);
  localparam logic [2:0] X_CALL  = 3'((WIDE ? CYC_CALL_W : CYC_CALL_N) - 2);
  localparam logic [2:0] X_RET   = 3'((WIDE ? CYC_RET_W : CYC_RET_N) - 1);
  localparam logic [2:0] X_BR    = 3'(CYC_BR_TAKEN - 1);

  // Logic-class flag update, S always derived from N and V
  function automatic bsm_flags_type logic_flags(bsm_flags_type f, logic [7:0] r, logic v);
    bsm_flags_type o;
    o   = f;
    o.z = (r == 8'h00);
    o.n = r[7];
    o.v = v;
    o.s = r[7] ^ v;
    return o;
  endfunction : logic_flags

  // Subtract flags; keep_z chains Z across multi-byte compares
  function automatic bsm_flags_type sub_flags(bsm_flags_type f, logic [7:0] d, logic [7:0] r,
                                              logic cin, logic keep_z);
    bsm_flags_type o;
    logic [7:0]    q;
    o   = f;
    q   = d - r - {7'h00, cin};
    o.h = (~d[3] & r[3]) | (r[3] & q[3]) | (q[3] & ~d[3]);
    o.v = (d[7] & ~r[7] & ~q[7]) | (~d[7] & r[7] & q[7]);
    o.n = q[7];
    o.s = o.n ^ o.v;
    o.z = (q == 8'h00) & (~keep_z | f.z);
    o.c = (~d[7] & r[7]) | (r[7] & q[7]) | (q[7] & ~d[7]);
    return o;
  endfunction : sub_flags

  function automatic logic is_long(logic [15:0] w);
    return (w[15:8] == OP8_JMP) || (w[15:8] == OP8_CALL);
  endfunction : is_long

  logic          [7:0]          regs_reg [32];
  logic          [PC_WIDTH-1:0] stack_reg [STACK_DEPTH];
  logic          [SPW-1:0]      sp_reg;
  logic          [PC_WIDTH-1:0] pc_reg;
  logic          [PC_WIDTH-1:0] pc_next;
  bsm_state_type                state_reg;
  bsm_state_type                state_next;
  logic          [2:0]          wait_reg;
  logic          [2:0]          wait_next;
  logic                         long_call_reg;
  logic                         long_call_next;
  bsm_flags_type                flags_reg;
  bsm_flags_type                flags_next;
  logic                         run_reg;
  logic          [7:0]          reg_rdata_reg;
  logic          [2:0]          extra;
  logic                         wr_en;
  logic          [7:0]          wr_data;
  logic                         mul_wr;
  logic                         push;
  logic                         pop;
  logic          [PC_WIDTH-1:0] push_data;

  wire logic [15:0]          instr    = imem_data;
  wire logic [3:0]           op_nib   = instr[15:12];
  wire logic [5:0]           op6      = instr[15:10];
  wire logic [7:0]           op8      = instr[15:8];
  wire logic [7:0]           imm      = instr[7:0];
  wire logic                 imm_form = (op_nib == NIB_SET_BITS) || (op_nib == NIB_CLR_BITS)
                                        || (op_nib == NIB_CMP_IMM);
  wire logic                 rb_form  = (op_nib == NIB_SKIP_RBC) || (op_nib == NIB_SKIP_RBS);
  wire logic [4:0]           rd_idx   = imm_form ? {1'b1, instr[11:8]} :
                                        (op_nib == NIB_MISC) ? instr[4:0] : instr[9:5];
  wire logic [4:0]           rr_idx   = rb_form ? instr[8:4] : instr[4:0];
  wire logic [7:0]           opa      = regs_reg[rd_idx];
  wire logic [7:0]           opb      = regs_reg[rr_idx];
  wire logic [7:0]           or_res   = opa | imm;
  wire logic [7:0]           andc_res = opa & (BYTE_ONES - imm);
  wire logic [7:0]           tst_res  = opa & opa;
  wire logic [7:0]           clr_res  = opa ^ opa;
  wire logic [7:0]           inc_res  = opa + 8'h01;
  wire logic [7:0]           dec_res  = opa - 8'h01;
  wire logic                 bit_sel  = opb[instr[2:0]];
  wire logic                 io_bit   = io_rdata[instr[2:0]];
  wire logic [7:0]           flag_vec = flags_reg;
  wire logic                 flag_bit = flag_vec[instr[2:0]];
  wire logic [PC_WIDTH-1:0]  pc_plus1 = pc_reg + PC_WIDTH'(1);
  wire logic [PC_WIDTH-1:0]  br_tgt   = pc_plus1 + PC_WIDTH'($signed(instr[9:3]));
  wire logic [PC_WIDTH-1:0]  rel_tgt  = pc_plus1 + PC_WIDTH'($signed(instr[11:0]));
  wire logic [PC_WIDTH-1:0]  z_ptr    = PC_WIDTH'({regs_reg[Z_HI_IDX], regs_reg[Z_LO_IDX]});
  wire logic [SPW-1:0]       sp_dec   = sp_reg - SPW'(1);
  wire logic [PC_WIDTH-1:0]  pop_data = stack_reg[sp_dec];

  // Multiplier operand signedness and fractional shift
  wire logic        sgn_a   = (op6 == OP6_MUL_SS) || (op6 == OP6_MUL_SU)
                              || (op6 == OP6_FRAC_MULTIPLY_UU_OP_SS) || (op6 == OP6_FRAC_MULTIPLY_UU_OP_SU);
  wire logic        sgn_b   = (op6 == OP6_MUL_SS) || (op6 == OP6_FRAC_MULTIPLY_UU_OP_SS);
  wire logic        frac    = (op6 == OP6_FRAC_MULTIPLY_UU_OP_UU) || (op6 == OP6_FRAC_MULTIPLY_UU_OP_SS)
                              || (op6 == OP6_FRAC_MULTIPLY_UU_OP_SU);
  wire logic [15:0] mul_a   = {{8{sgn_a & opa[7]}}, opa};
  wire logic [15:0] mul_b   = {{8{sgn_b & opb[7]}}, opb};
  wire logic [15:0] product = 16'(mul_a * mul_b);
  wire logic [15:0] mul_res = frac ? {product[14:0], 1'b0} : product;

  // Bus writes hold off execution for one cycle so the two never collide
  wire logic fire = run_reg && !reg_wr;

  assign imem_addr = pc_reg;
  assign io_addr   = instr[7:3];
  assign reg_rdata = reg_rdata_reg;
  assign flags     = flags_reg;
  assign busy      = (state_reg != ST_EXEC);

  always_comb begin
    state_next     = ST_EXEC;
    pc_next        = pc_reg;
    wait_next      = wait_reg;
    flags_next     = flags_reg;
    long_call_next = long_call_reg;
    extra          = 3'h0;
    wr_en          = 1'b0;
    wr_data        = 8'h00;
    mul_wr         = 1'b0;
    push           = 1'b0;
    pop            = 1'b0;
    push_data      = pc_plus1;
    case (state_reg)
      ST_EXEC: begin
        pc_next = pc_plus1;
        case (op_nib)
          NIB_MISC: begin
            case (op8)
              OP8_INC: begin
                wr_en      = 1'b1;
                wr_data    = inc_res;
                flags_next = logic_flags(flags_reg, inc_res, opa == 8'h7f);
              end
              OP8_DEC: begin
                wr_en      = 1'b1;
                wr_data    = dec_res;
                flags_next = logic_flags(flags_reg, dec_res, opa == 8'h80);
              end
              OP8_TST: flags_next = logic_flags(flags_reg, tst_res, 1'b0);
              OP8_CLRR: begin
                wr_en      = 1'b1;
                wr_data    = clr_res;
                flags_next = logic_flags(flags_reg, clr_res, 1'b0);
              end
              OP8_SETR: begin
                wr_en   = 1'b1;
                wr_data = BYTE_ONES;
              end
              OP8_INDIRECT_JUMP_OP: begin
                pc_next = z_ptr;
                extra   = X_INDIRECT_JUMP_OP;
              end
              OP8_INDIRECT_SUBROUTINE_OP: begin
                push    = 1'b1;
                pc_next = z_ptr;
                extra   = X_RELATIVE_SUBROUTINE_OP;
              end
              OP8_RET, OP8_INTERRUPT_RETURN_OP: begin
                pop     = 1'b1;
                pc_next = pop_data;
                extra   = X_RET;
                if (op8 == OP8_INTERRUPT_RETURN_OP) begin
                  flags_next.i = 1'b1;
                end
              end
              OP8_JMP, OP8_CALL: begin
                long_call_next = (op8 == OP8_CALL);
                state_next     = ST_LONG;
              end
              default: ;
            endcase
          end
          NIB_SET_BITS: begin
            wr_en      = 1'b1;
            wr_data    = or_res;
            flags_next = logic_flags(flags_reg, or_res, 1'b0);
          end
          NIB_CLR_BITS: begin
            wr_en      = 1'b1;
            wr_data    = andc_res;
            flags_next = logic_flags(flags_reg, andc_res, 1'b0);
          end
          NIB_CMP_IMM: flags_next = sub_flags(flags_reg, opa, imm, 1'b0, 1'b0);
          // Named branches are this pair with a fixed flag index
          NIB_BR_SET, NIB_BR_CLR: begin
            if (flag_bit == (op_nib == NIB_BR_SET)) begin
              pc_next = br_tgt;
              extra   = X_BR;
            end
          end
          NIB_REL_JMP: begin
            pc_next = rel_tgt;
            extra   = X_RELATIVE_JUMP_OP;
          end
          NIB_REL_CALL: begin
            push    = 1'b1;
            pc_next = rel_tgt;
            extra   = X_RELATIVE_SUBROUTINE_OP;
          end
          NIB_SKIP_RBC, NIB_SKIP_RBS: begin
            if (bit_sel == (op_nib == NIB_SKIP_RBS)) begin
              state_next = ST_SKIP;
            end
          end
          NIB_SKIP_IBC, NIB_SKIP_IBS: begin
            if (io_bit == (op_nib == NIB_SKIP_IBS)) begin
              state_next = ST_SKIP;
            end
          end
          4'hc, 4'hd, 4'he: begin
            case (op6)
              OP6_MUL_UU, OP6_MUL_SS, OP6_MUL_SU,
              OP6_FRAC_MULTIPLY_UU_OP_UU, OP6_FRAC_MULTIPLY_UU_OP_SS, OP6_FRAC_MULTIPLY_UU_OP_SU: begin
                mul_wr       = 1'b1;
                flags_next.c = product[15];
                flags_next.z = (mul_res == 16'h0000);
                extra        = X_MUL;
              end
              OP6_COMPARE_SKIP_EQUAL_OP: begin
                if (opa == opb) begin
                  state_next = ST_SKIP;
                end
              end
              OP6_CP:  flags_next = sub_flags(flags_reg, opa, opb, 1'b0, 1'b0);
              OP6_CPC: flags_next = sub_flags(flags_reg, opa, opb, flags_reg.c, 1'b1);
              default: ;
            endcase
          end
          default: ;
        endcase
      end
      // Skipped word is fetched and dropped; a long word costs one more cycle
      ST_SKIP: begin
        if (is_long(instr)) begin
          pc_next = pc_reg + PC_WIDTH'(2);
          extra   = 3'h1;
        end else begin
          pc_next = pc_plus1;
        end
      end
      ST_LONG: begin
        pc_next = PC_WIDTH'(instr);
        if (long_call_reg) begin
          push  = 1'b1;
          extra = X_CALL;
        end else begin
          extra = X_JMP;
        end
      end
      ST_WAIT: begin
        if (wait_reg > 3'h1) begin
          state_next = ST_WAIT;
          wait_next  = wait_reg - 3'h1;
        end
      end
      default: ;
    endcase
    if (extra != 3'h0) begin
      state_next = ST_WAIT;
      wait_next  = extra;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg     <= ST_EXEC;
      pc_reg        <= '0;
      wait_reg      <= 3'h0;
      long_call_reg <= 1'b0;
      sp_reg        <= '0;
    end else if (ce && fire) begin
      state_reg     <= state_next;
      pc_reg        <= pc_next;
      wait_reg      <= wait_next;
      long_call_reg <= long_call_next;
      if (push) begin
        stack_reg[sp_reg] <= push_data;
        sp_reg            <= sp_reg + SPW'(1);
      end else if (pop) begin
        sp_reg <= sp_dec;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < 32; i++) begin
        regs_reg[i] <= 8'h00;
      end
    end else if (ce) begin
      if (reg_wr && (reg_addr[5] == 1'b0)) begin
        regs_reg[reg_addr[4:0]] <= reg_wdata;
      end else if (fire && wr_en && (state_reg == ST_EXEC)) begin
        regs_reg[rd_idx] <= wr_data;
      end else if (fire && mul_wr && (state_reg == ST_EXEC)) begin
        regs_reg[1] <= mul_res[15:8];
        regs_reg[0] <= mul_res[7:0];
      end
    end
  end

  wire bsm_flags_type bus_flags = '{i: reg_wdata[7], t: reg_wdata[6], h: reg_wdata[5],
                                    s: reg_wdata[3] ^ reg_wdata[2], v: reg_wdata[3],
                                    n: reg_wdata[2], z: reg_wdata[1], c: reg_wdata[0]};

  always_ff @(posedge core_clk) begin
    if (reset) begin
      flags_reg <= FLAGS_RESET;
      run_reg   <= CTRL_RESET;
    end else if (ce) begin
      if (reg_wr && (reg_addr == RB_FLAGS)) begin
        flags_reg <= bus_flags;
      end else if (fire) begin
        flags_reg <= flags_next;
      end
      if (reg_wr && (reg_addr == RB_CTRL)) begin
        run_reg <= reg_wdata[0];
      end
    end
  end

  wire logic [15:0] pc_wide = 16'(pc_reg);
  wire logic [7:0]  rd_mux  = (reg_addr[5] == 1'b0) ? regs_reg[reg_addr[4:0]] :
                              (reg_addr == RB_FLAGS)  ? flag_vec :
                              (reg_addr == RB_PC_LO)  ? pc_wide[7:0] :
                              (reg_addr == RB_PC_HI)  ? pc_wide[15:8] :
                              (reg_addr == RB_CTRL)   ? {7'h00, run_reg} :
                              (reg_addr == RB_STATUS) ? {7'h00, busy} : 8'h00;

  // Read data stands one cycle only; otherwise zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata_reg <= 8'h00;
    end else if (ce) begin
      reg_rdata_reg <= reg_rd ? rd_mux : 8'h00;
    end
  end

endmodule : bsm_core

// ===== rtl/bsm_pkg.sv
// Package with encodings, flag positions, bus map and cycle counts of the execution core
package bsm_pkg;

  // Flag layout, bit 7 down to bit 0
  typedef struct packed {
    logic i;
    logic t;
    logic h;
    logic s;
    logic v;
    logic n;
    logic z;
    logic c;
  } bsm_flags_type;

  typedef enum logic [1:0] {
    ST_EXEC = 2'b00,
    ST_WAIT = 2'b01,
    ST_SKIP = 2'b10,
    ST_LONG = 2'b11
  } bsm_state_type;

  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  // Top nibble classes
  localparam logic [3:0] NIB_MISC     = 4'h0;
  localparam logic [3:0] NIB_SET_BITS = 4'h1;
  localparam logic [3:0] NIB_CLR_BITS = 4'h2;
  localparam logic [3:0] NIB_CMP_IMM  = 4'h3;
  localparam logic [3:0] NIB_BR_SET   = 4'h4;
  localparam logic [3:0] NIB_BR_CLR   = 4'h5;
  localparam logic [3:0] NIB_REL_JMP  = 4'h6;
  localparam logic [3:0] NIB_REL_CALL = 4'h7;
  localparam logic [3:0] NIB_SKIP_RBC = 4'h8;
  localparam logic [3:0] NIB_SKIP_RBS = 4'h9;
  localparam logic [3:0] NIB_SKIP_IBC = 4'ha;
  localparam logic [3:0] NIB_SKIP_IBS = 4'hb;

  // Misc class, code in bits 15:8, register in bits 4:0
  localparam logic [7:0] OP8_INC   = 8'h01;
  localparam logic [7:0] OP8_DEC   = 8'h02;
  localparam logic [7:0] OP8_TST   = 8'h03;
  localparam logic [7:0] OP8_CLRR  = 8'h04;
  localparam logic [7:0] OP8_SETR  = 8'h05;
  localparam logic [7:0] OP8_INDIRECT_JUMP_OP  = 8'h08;
  localparam logic [7:0] OP8_INDIRECT_SUBROUTINE_OP = 8'h09;
  localparam logic [7:0] OP8_RET   = 8'h0a;
  localparam logic [7:0] OP8_INTERRUPT_RETURN_OP  = 8'h0b;
  localparam logic [7:0] OP8_JMP   = 8'h0c;
  localparam logic [7:0] OP8_CALL  = 8'h0d;

  // Two-register class, code in bits 15:10
  localparam logic [5:0] OP6_MUL_UU  = 6'h30;
  localparam logic [5:0] OP6_MUL_SS  = 6'h31;
  localparam logic [5:0] OP6_MUL_SU  = 6'h32;
  localparam logic [5:0] OP6_FRAC_MULTIPLY_UU_OP_UU = 6'h33;
  localparam logic [5:0] OP6_FRAC_MULTIPLY_UU_OP_SS = 6'h34;
  localparam logic [5:0] OP6_FRAC_MULTIPLY_UU_OP_SU = 6'h35;
  localparam logic [5:0] OP6_COMPARE_SKIP_EQUAL_OP    = 6'h36;
  localparam logic [5:0] OP6_CP      = 6'h37;
  localparam logic [5:0] OP6_CPC     = 6'h38;

  localparam logic [7:0] BYTE_ONES = 8'hff;
  localparam logic [4:0] Z_LO_IDX  = 5'h1e;
  localparam logic [4:0] Z_HI_IDX  = 5'h1f;
  localparam int         IO_ADDR_W = 5;

  // Register port map
  localparam logic [5:0] RB_STATUS = 6'h3b;
  localparam logic [5:0] RB_CTRL   = 6'h3c;
  localparam logic [5:0] RB_PC_LO  = 6'h3d;
  localparam logic [5:0] RB_PC_HI  = 6'h3e;
  localparam logic [5:0] RB_FLAGS  = 6'h3f;

  localparam logic          CTRL_RESET  = 1'b0;
  localparam bsm_flags_type FLAGS_RESET = '0;

  // Cycle counts
  localparam int CYC_MUL       = 2;
  localparam int CYC_INDIRECT_JUMP_OP      = 2;
  localparam int CYC_RELATIVE_JUMP_OP      = 2;
  localparam int CYC_JMP       = 3;
  localparam int CYC_RELATIVE_SUBROUTINE_OP_N   = 2;
  localparam int CYC_RELATIVE_SUBROUTINE_OP_W   = 3;
  localparam int CYC_CALL_N    = 3;
  localparam int CYC_CALL_W    = 4;
  localparam int CYC_RET_N     = 4;
  localparam int CYC_RET_W     = 5;
  localparam int CYC_BR_TAKEN  = 2;
  localparam int NARROW_PC_MAX = 16;

endpackage : bsm_pkg

// ===== tb/bsm_core_props.sv
// Port-level checker for the execution core
`timescale 1ns/1ps
module bsm_core_props
  import bsm_pkg::*;
#(
  parameter int PC_WIDTH = 16
) (
  input wire logic                 core_clk,
  input wire logic                 reset,
  input wire logic                 ce,
  input wire logic [PC_WIDTH-1:0]  imem_addr,
  input wire logic [15:0]          imem_data,
  input wire logic [IO_ADDR_W-1:0] io_addr,
  input wire logic [7:0]           io_rdata,
  input wire logic [5:0]           reg_addr,
  input wire logic [7:0]           reg_wdata,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire logic [7:0]           reg_rdata,
  input wire bsm_flags_type        flags,
  input wire logic                 busy
);
  logic                run_reg;
  logic                exec;
  logic                hit;
  logic [3:0]          nib;
  logic [PC_WIDTH-1:0] pc_inc;
  logic [PC_WIDTH-1:0] br_tgt;
  // Run bit shadowed here since the checker cannot see the control register
  always_ff @(posedge core_clk) begin
    if (reset) run_reg <= 1'b0;
    else if (ce && reg_wr && reg_addr == RB_CTRL) run_reg <= reg_wdata[0];
  end
  assign exec   = run_reg && ce && !busy && !reg_wr;
  assign nib    = imem_data[15:12];
  assign hit    = flags[imem_data[2:0]];
  assign pc_inc = imem_addr + PC_WIDTH'(1);
  assign br_tgt = pc_inc + PC_WIDTH'($signed(imem_data[9:3]));
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  a_sign_flag_xor: assert property (flags.s == (flags.n ^ flags.v))
    else $error("sign flag differs from n xor v");
  a_io_addr_field: assert property (io_addr == imem_data[7:3])
    else $error("io address not taken from word");
  a_set_bits_single: assert property (exec && nib == NIB_SET_BITS |=>
    !busy && imem_addr == $past(pc_inc)) else $error("set bits not one cycle");
  a_mul_two_cycles: assert property (exec && imem_data[15:10] >= OP6_MUL_UU &&
    imem_data[15:10] <= OP6_FRAC_MULTIPLY_UU_OP_SU |=> busy && imem_addr == $past(pc_inc) ##1 !busy)
    else $error("multiply not two cycles");
  a_branch_set_taken: assert property (exec && nib == NIB_BR_SET && hit |=>
    busy && imem_addr == $past(br_tgt) && $stable(flags)) else $error("set branch wrong");
  a_branch_clr_taken: assert property (exec && nib == NIB_BR_CLR && !hit |=>
    busy && imem_addr == $past(br_tgt) && $stable(flags)) else $error("clear branch wrong");
  a_branch_not_taken: assert property (exec &&
    ((nib == NIB_BR_SET && !hit) || (nib == NIB_BR_CLR && hit)) |=>
    !busy && imem_addr == $past(pc_inc)) else $error("untaken branch wrong");
  a_indirect_jump_op_keeps_flags: assert property (exec && imem_data[15:8] == OP8_INDIRECT_JUMP_OP |=>
    busy && $stable(flags)) else $error("indirect jump timing or flags wrong");
  a_ser_keeps_flags: assert property (exec && imem_data[15:8] == OP8_SETR |=>
    $stable(flags)) else $error("set register changed flags");
endmodule : bsm_core_props

// ===== tb/bsm_imem_model.sv
// Program memory model answering the core's fetch address in the same cycle
`timescale 1ns/1ps
module bsm_imem_model
  import bsm_pkg::*;
#(
  parameter int AW = 16
) (
  input  wire logic [AW-1:0] addr,
  output logic      [15:0]   data
);
  // Small on purpose; fetches past the end see an unused encoding
  logic [15:0] mem [16];
  initial mem = '{default: 16'hffff};
  assign data = (addr < AW'(16)) ? mem[addr[3:0]] : 16'hffff;
endmodule : bsm_imem_model

// ===== tb/tb.sv
// Self-checking bench for the execution core
`timescale 1ns/1ps
module tb;
  import bsm_pkg::*;
  logic                 core_clk  = 1'b0;
  logic                 reset     = 1'b1;
  logic                 ce        = 1'b1;
  logic [15:0]          imem_addr;
  logic [15:0]          imem_data;
  logic [IO_ADDR_W-1:0] io_addr;
  logic [7:0]           io_rdata  = 8'h00;
  logic [5:0]           reg_addr  = 6'h00;
  logic [7:0]           reg_wdata = 8'h00;
  logic                 reg_wr    = 1'b0;
  logic                 reg_rd    = 1'b0;
  logic [7:0]           reg_rdata;
  bsm_flags_type        flags;
  logic                 busy;
  logic [7:0]           a, b, c, k, f, r7, rv;
  int                   err_count = 0;
  int                   checks    = 0;
  int                   i, kind, bb, ia, ib, p, res;
  always #5 core_clk = ~core_clk;
  bsm_core #(.PC_WIDTH(16), .STACK_DEPTH(16)) u_bsm_core (.core_clk(core_clk), .reset(reset),
    .ce(ce), .imem_addr(imem_addr), .imem_data(imem_data), .io_addr(io_addr),
    .io_rdata(io_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flags(flags), .busy(busy));
  bsm_imem_model #(.AW(16)) u_bsm_imem_model (.addr(imem_addr), .data(imem_data));
  task automatic stop_test();
    $display("checks=%0d errors=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // A gap cycle after each strobe keeps one assignment per signal per step
  task automatic wr(input logic [5:0] ad, input logic [7:0] d);
    reg_addr  <= ad;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [5:0] ad);
    reg_addr <= ad;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
    @(posedge core_clk);
  endtask : rd
  task automatic boot(input logic [15:0] prog[$]);
    reset <= 1'b1;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    for (int j = 0; j < 16; j++) u_bsm_imem_model.mem[j] = (j < prog.size()) ? prog[j] : 16'hffff;
  endtask : boot
  // Runs until the closing self-loop is reached, then halts the core
  task automatic go(input int fin);
    int n;
    wr(RB_CTRL, 8'h01);
    for (n = 0; n < 200 && imem_addr !== 16'(fin); n++) @(posedge core_clk);
    chk(imem_addr, 16'(fin));
    repeat (4) @(posedge core_clk);
    wr(RB_CTRL, 8'h00);
    rd(RB_PC_LO);
    chk(rv, 8'(fin));
  endtask : go
  initial begin
    #200000;
    err_count++;
    stop_test();
  end
  initial begin
    void'($urandom(52));
    boot('{16'h6fff});
    // Strobes with the enable low must be lost
    ce <= 1'b0;
    wr(RB_FLAGS, 8'hff);
    ce <= 1'b1;
    rd(RB_FLAGS);
    chk(rv, 8'h00);
    rd(6'h20);
    chk(rv, 8'h00);
    a = $urandom;
    b = $urandom;
    c = $urandom;
    k = $urandom;
    boot('{{4'h1, 4'h0, k}, {4'h2, 4'h1, k}, 16'h0113, 16'h0214, 16'h0312, 16'h6fff});
    wr(6'h10, a);
    wr(6'h11, b);
    wr(6'h12, c);
    wr(6'h13, 8'h7f);
    go(5);
    rd(6'h10);
    chk(rv, a | k);
    rd(6'h11);
    chk(rv, b & (8'hff - k));
    rd(6'h13);
    chk(rv, 8'h80);
    rd(6'h14);
    chk(rv, 8'hff);
    rd(6'h12);
    chk(rv, c);
    rd(RB_FLAGS);
    chk(rv, {3'b000, c[7], 1'b0, c[7], c == 8'h00, 1'b0});
    for (i = 0; i < 6; i++) begin
      a = $urandom;
      b = $urandom;
      ia = (i % 3 == 0) ? int'(a) : int'($signed(a));
      ib = (i % 3 == 1) ? int'($signed(b)) : int'(b);
      p = (ia * ib) & 32'hffff;
      res = (i >= 3) ? (p << 1) & 32'hffff : p;
      boot('{{OP6_MUL_UU + 6'(i), 5'h02, 5'h03}, 16'h6fff});
      wr(6'h02, a);
      wr(6'h03, b);
      go(1);
      rd(6'h00);
      chk(rv, res[7:0]);
      rd(6'h01);
      chk(rv, res[15:8]);
      rd(RB_FLAGS);
      chk(rv, {6'h00, res == 0, p[15]});
    end
    for (i = 0; i < 16; i++) begin
      f = $urandom;
      f[4] = f[2] ^ f[3];
      boot('{{(i < 8) ? 4'h4 : 4'h5, 2'b00, 7'h02, 3'(i)}, 16'h0514, 16'h0515, 16'h6fff});
      wr(RB_FLAGS, f);
      go(3);
      rd(6'h14);
      chk(rv, (f[i % 8] == (i < 8)) ? 8'h00 : 8'hff);
      rd(RB_FLAGS);
      chk(rv, f);
      chk(flags, f);
    end
    for (i = 0; i < 10; i++) begin
      kind = i % 5;
      a = $urandom;
      bb = $urandom % 8;
      r7 = (i < 5) ? a : a ^ 8'h01;
      io_rdata <= a;
      boot('{(kind == 4) ? {OP6_COMPARE_SKIP_EQUAL_OP, 5'h06, 5'h07} : {4'(8 + kind), 3'b000, 5'h05, 1'b0,
        3'(bb)}, 16'h0c00, 16'h0004, 16'h0514, 16'h6fff});
      wr(6'h05, a);
      wr(6'h06, a);
      wr(6'h07, r7);
      go(4);
      rd(6'h14);
      chk(rv, ((kind == 4) ? (r7 == a) : (a[bb] == kind[0])) ? 8'hff : 8'h00);
      rd(RB_FLAGS);
      chk(rv, 8'h00);
    end
    for (i = 0; i < 2; i++) begin
      boot('{i ? 16'h0900 : 16'h0800, 16'h0514, 16'h6fff, 16'hffff, 16'h0515,
        i ? 16'h0b00 : 16'h6ffc});
      wr(6'h1e, 8'h04);
      go(2);
      rd(6'h14);
      chk(rv, i ? 8'hff : 8'h00);
      rd(6'h15);
      chk(rv, 8'hff);
      rd(RB_FLAGS);
      chk(rv, i ? 8'h80 : 8'h00);
    end
    // Compares: flags from integer borrow and signed range, no result stored
    for (i = 0; i < 3; i++) begin
      a = $urandom;
      b = $urandom;
      f = $urandom;
      f[4] = f[2] ^ f[3];
      ia = (i == 2) ? int'(f[0]) : 0;
      p = int'(a) - int'(b) - ia;
      res = int'($signed(a)) - int'($signed(b)) - ia;
      kind = (res < -128 || res > 127) ? 1 : 0;
      r7 = 8'(p);
      bb = (int'(a[3:0]) < int'(b[3:0]) + ia) ? 1 : 0;
      ib = ((r7 == 8'h00) && (i < 2 || f[1])) ? 1 : 0;
      boot('{(i == 0) ? {4'h3, 4'h0, b} : {(i == 1) ? OP6_CP : OP6_CPC, 5'h10, 5'h11},
        16'h6fff});
      wr(6'h10, a);
      wr(6'h11, b);
      wr(RB_FLAGS, f);
      go(1);
      rd(6'h10);
      chk(rv, a);
      rd(RB_FLAGS);
      chk(rv, {f[7:6], bb[0], r7[7] ^ kind[0], kind[0], r7[7], ib[0], p < 0});
    end
    stop_test();
  end
endmodule : tb
bind bsm_core bsm_core_props #(.PC_WIDTH(PC_WIDTH)) u_bsm_core_props (.core_clk(core_clk),
  .reset(reset), .ce(ce), .imem_addr(imem_addr), .imem_data(imem_data), .io_addr(io_addr),
  .io_rdata(io_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flags(flags), .busy(busy));
